// [logic/udrt_timer.sv]
`timescale 1ns/1ps
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
////////////////////////////////////////////////////////////////////////////////
module udrt_timer (
   // Clock and reset.
   input  wire logic        mclk,
   input  wire logic        rst,
   // APB slave.
   input  wire logic [11:0] paddr,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   // Pins and system state.
   input  wire logic        direction_pin,
   input  wire logic        event_input_pin,
   input  wire logic        subclock_pin,
   input  wire logic        low_speed_mode,
   // Interrupt request.
   output logic             timer_irq
);

   ////////////////////////////////////////////////////////////////////////////
   // Registers.
   logic [7:0]  timer_mode_control;
   logic [7:0]  count_value;
   logic [7:0]  reload_value;
   logic [7:0]  module_standby_control;
   logic        timer_request_flag;
   logic        timer_interrupt_enable;
   logic        event_edge_select;

   // Pin synchronisers and edge history.
   logic        dir_s1;
   logic        dir_s2;
   logic        evt_s1;
   logic        evt_s2;
   logic        evt_s3;
   logic        sub_s1;
   logic        sub_s2;
   logic        sub_s3;
   logic [1:0]  sub_div;

   // Decoding.
   logic        access;
   logic        wr_mode;
   logic        wr_count;
   logic        wr_standby;
   logic        wr_irq;
   logic        hit_mode;
   logic        hit_count;
   logic        hit_standby;
   logic        hit_irq;
   logic        mapped;
   logic        clear_flag;

   // Counting.
   logic [2:0]  source_select;
   logic        reload_mode_select;
   logic        direction_source_select;
   logic        software_direction;
   logic        timer_standby_bit;
   logic        internal_tick;
   logic        event_tick;
   logic        sub_rise;
   logic        sub_tick;
   logic        slow_source;
   logic        src_tick;
   logic        advance;
   logic        count_up;
   logic        at_limit;
   logic        limit_event;
   logic [7:0]  wrap_value;
   logic [7:0]  step_value;
   logic [7:0]  next_count;
   logic [7:0]  next_mode;
   logic        next_flag;
   logic [31:0] read_mux;

   ////////////////////////////////////////////////////////////////////////////
   // Bus decode.
   assign access      = psel && penable;
   assign hit_mode    = (paddr == udrt_pkg::ADDR_MODE);
   assign hit_count   = (paddr == udrt_pkg::ADDR_COUNT);
   assign hit_standby = (paddr == udrt_pkg::ADDR_STANDBY);
   assign hit_irq     = (paddr == udrt_pkg::ADDR_IRQ);
   assign mapped      = hit_mode || hit_count || hit_standby || hit_irq;
   assign wr_mode     = access && pwrite && hit_mode;
   assign wr_count    = access && pwrite && hit_count;
   assign wr_standby  = access && pwrite && hit_standby;
   assign wr_irq      = access && pwrite && hit_irq;
   assign clear_flag  = wr_irq && pwdata[udrt_pkg::IRQ_FLAG_BIT];
   assign pready      = 1'b1;
   assign pslverr     = access && !mapped;

   // Reads return the counter at the shared address and fixed ones in the mode.
   assign read_mux = hit_mode    ? {24'h0, timer_mode_control} :
                     hit_count   ? {24'h0, count_value} :
                     hit_standby ? {24'h0, module_standby_control} :
                     hit_irq     ? {29'h0, event_edge_select, timer_interrupt_enable,
                                    timer_request_flag} :
                                   udrt_pkg::READ_ZERO;
   assign prdata   = (psel && !pwrite) ? read_mux : udrt_pkg::READ_ZERO;

   // Fixed bits are forced high whatever software writes.
   assign next_mode = pwdata[7:0] | udrt_pkg::MODE_FIXED_ONES;

   ////////////////////////////////////////////////////////////////////////////
   // Mode fields.
   assign reload_mode_select      = timer_mode_control[udrt_pkg::MODE_RELOAD_BIT];
   assign direction_source_select = timer_mode_control[udrt_pkg::MODE_DIRSRC_BIT];
   assign software_direction      = timer_mode_control[udrt_pkg::MODE_SWDIR_BIT];
   assign source_select           = timer_mode_control[udrt_pkg::MODE_SRC_MSB:
                                                       udrt_pkg::MODE_SRC_LSB];
   assign timer_standby_bit       = module_standby_control[udrt_pkg::STANDBY_BIT];

   // Direction from the field, or from the pin with high meaning down.
   assign count_up = direction_source_select ? !dir_s2 : !software_direction;

   ////////////////////////////////////////////////////////////////////////////
   // Count sources.
   udrt_prescaler u_prescaler (
      .mclk          (mclk),
      .rst           (rst),
      .source_select (source_select),
      .internal_tick (internal_tick)
   );

   assign event_tick  = event_edge_select ? (evt_s2 && !evt_s3) : (!evt_s2 && evt_s3);
   assign sub_rise    = sub_s2 && !sub_s3;
   assign sub_tick    = sub_rise && (sub_div == udrt_pkg::SUB_DIV_LAST);
   assign slow_source = (source_select == udrt_pkg::SRC_SUB4) ||
                        (source_select == udrt_pkg::SRC_EVENT);

   // Low-speed mode blocks every prescaled source.
   assign src_tick = (source_select == udrt_pkg::SRC_EVENT) ? event_tick :
                     (source_select == udrt_pkg::SRC_SUB4)  ? sub_tick :
                     (internal_tick && !low_speed_mode);
   assign advance  = src_tick && timer_standby_bit;

   ////////////////////////////////////////////////////////////////////////////
   // Counter next value.
   assign at_limit    = count_up ? (count_value == udrt_pkg::COUNT_MAX) :
                                   (count_value == udrt_pkg::COUNT_MIN);
   assign limit_event = advance && at_limit;
   assign wrap_value  = reload_mode_select ? reload_value :
                        (count_up ? udrt_pkg::COUNT_MIN : udrt_pkg::COUNT_MAX);
   assign step_value  = count_up ? count_value + 8'h01 : count_value - 8'h01;
   assign next_count  = wr_count ? pwdata[7:0] :
                        !advance ? count_value :
                        at_limit ? wrap_value : step_value;
   // A limit event in the cycle of a clear keeps the flag set.
   assign next_flag   = limit_event || (timer_request_flag && !clear_flag);

   assign timer_irq   = timer_request_flag && timer_interrupt_enable;

   ////////////////////////////////////////////////////////////////////////////
   // Pin synchronisers.
   always_ff @(posedge mclk) begin
      if (rst) begin
         dir_s1 <= 1'b0;
         dir_s2 <= 1'b0;
         evt_s1 <= 1'b0;
         evt_s2 <= 1'b0;
         evt_s3 <= 1'b0;
         sub_s1 <= 1'b0;
         sub_s2 <= 1'b0;
         sub_s3 <= 1'b0;
      end else begin
         dir_s1 <= direction_pin;
         dir_s2 <= dir_s1;
         evt_s1 <= event_input_pin;
         evt_s2 <= evt_s1;
         evt_s3 <= evt_s2;
         sub_s1 <= subclock_pin;
         sub_s2 <= sub_s1;
         sub_s3 <= sub_s2;
      end
   end

   // Subclock divide by four.
   always_ff @(posedge mclk) begin
      if (rst) begin
         sub_div <= 2'h0;
      end else if (sub_rise) begin
         sub_div <= sub_div + 2'h1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Software registers.
   always_ff @(posedge mclk) begin
      if (rst) begin
         timer_mode_control     <= udrt_pkg::MODE_RESET;
         reload_value           <= udrt_pkg::RELOAD_RESET;
         module_standby_control <= udrt_pkg::STANDBY_RESET;
         timer_interrupt_enable <= 1'b0;
         event_edge_select      <= 1'b0;
      end else begin
         if (wr_mode) begin
            timer_mode_control <= next_mode;
         end
         if (wr_count) begin
            reload_value <= pwdata[7:0];
         end
         if (wr_standby) begin
            module_standby_control <= pwdata[7:0];
         end
         if (wr_irq) begin
            timer_interrupt_enable <= pwdata[udrt_pkg::IRQ_EN_BIT];
            event_edge_select      <= pwdata[udrt_pkg::IRQ_EDGE_BIT];
         end
      end
   end

   // Counter and request flag.
   always_ff @(posedge mclk) begin
      if (rst) begin
         count_value        <= udrt_pkg::COUNT_RESET;
         timer_request_flag <= 1'b0;
      end else begin
         count_value        <= next_count;
         timer_request_flag <= next_flag;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Checks.
   default clocking cb @(posedge mclk); endclocking
   default disable iff (rst);

   property p_interval_wrap;
      advance && !wr_count && !reload_mode_select && at_limit |=>
         count_value == ($past(count_up) ? udrt_pkg::COUNT_MIN : udrt_pkg::COUNT_MAX);
   endproperty
   a_interval_wrap: assert property (p_interval_wrap)
      else $error("Interval wrap value wrong.");

   property p_reload_load;
      advance && !wr_count && reload_mode_select && at_limit |=>
         count_value == $past(reload_value);
   endproperty
   a_reload_load: assert property (p_reload_load)
      else $error("Reload value not loaded at limit.");

   property p_flag_set;
      limit_event |=> timer_request_flag;
   endproperty
   a_flag_set: assert property (p_flag_set)
      else $error("Request flag not set at limit.");

   property p_irq;
      limit_event && timer_interrupt_enable && !wr_irq |=> timer_irq;
   endproperty
   a_irq: assert property (p_irq)
      else $error("Interrupt request does not follow flag and enable.");

   property p_write_loads;
      wr_count |=> count_value == $past(pwdata[7:0]) && reload_value == $past(pwdata[7:0]);
   endproperty
   a_write_loads: assert property (p_write_loads)
      else $error("Reload write not copied to counter.");

   property p_standby_halt;
      !timer_standby_bit && !wr_count |=> count_value == $past(count_value);
   endproperty
   a_standby_halt: assert property (p_standby_halt)
      else $error("Counter moved in standby.");

   property p_fixed_bits;
      psel && !pwrite && hit_mode |-> prdata[4:3] == 2'h3;
   endproperty
   a_fixed_bits: assert property (p_fixed_bits)
      else $error("Mode fixed bits not read as one.");

   property p_count_read;
      psel && !pwrite && hit_count |-> prdata[7:0] == count_value;
   endproperty
   a_count_read: assert property (p_count_read)
      else $error("Counter read returned wrong value.");

   property p_step_down;
      advance && !wr_count && !count_up && !at_limit |=>
         count_value == $past(count_value) - 8'h01;
   endproperty
   a_step_down: assert property (p_step_down)
      else $error("Down count step wrong.");

   property p_low_speed;
      low_speed_mode && !slow_source && !wr_count |=> count_value == $past(count_value);
   endproperty
   a_low_speed: assert property (p_low_speed)
      else $error("Counter moved on a fast source in low-speed mode.");

   property p_reset_state;
      $past(rst) |-> timer_mode_control == udrt_pkg::MODE_RESET &&
                     count_value == udrt_pkg::COUNT_RESET;
   endproperty
   a_reset_state: assert property (p_reset_state)
      else $error("Reset state wrong.");

   property p_pin_direction;
      advance && !wr_count && direction_source_select && dir_s2 && !at_limit |=>
         count_value == $past(count_value) - 8'h01;
   endproperty
   a_pin_direction: assert property (p_pin_direction)
      else $error("Pin high did not select down count.");

endmodule // udrt_timer
`default_nettype wire

// [logic/udrt_pkg.sv]
`default_nettype none
package udrt_pkg;

   // Register byte offsets on the APB.
   localparam logic [11:0] ADDR_MODE       = 12'h000;
   localparam logic [11:0] ADDR_COUNT      = 12'h004;
   localparam logic [11:0] ADDR_STANDBY    = 12'h008;
   localparam logic [11:0] ADDR_IRQ        = 12'h00c;

   // Field positions of the mode register.
   localparam int          MODE_RELOAD_BIT = 7;
   localparam int          MODE_DIRSRC_BIT = 6;
   localparam int          MODE_SWDIR_BIT  = 5;
   localparam int          MODE_SRC_MSB    = 2;
   localparam int          MODE_SRC_LSB    = 0;

   // Field positions of the standby and interrupt control registers.
   localparam int          STANDBY_BIT     = 1;
   localparam int          IRQ_FLAG_BIT    = 0;
   localparam int          IRQ_EN_BIT      = 1;
   localparam int          IRQ_EDGE_BIT    = 2;

   // Reset values and fixed bits.
   localparam logic [7:0]  MODE_RESET      = 8'h18;
   localparam logic [7:0]  MODE_FIXED_ONES = 8'h18;
   localparam logic [7:0]  COUNT_RESET     = 8'h00;
   localparam logic [7:0]  RELOAD_RESET    = 8'h00;
   localparam logic [7:0]  STANDBY_RESET   = 8'hff;
   localparam logic [31:0] READ_ZERO       = 32'h0000_0000;

   // Counter limits.
   localparam logic [7:0]  COUNT_MAX       = 8'hff;
   localparam logic [7:0]  COUNT_MIN       = 8'h00;

   // Prescaler width and divide masks.
   localparam int          PRESCALE_WIDTH  = 13;
   localparam logic [12:0] MASK_DIV8192    = 13'h1fff;
   localparam logic [12:0] MASK_DIV2048    = 13'h07ff;
   localparam logic [12:0] MASK_DIV512     = 13'h01ff;
   localparam logic [12:0] MASK_DIV64      = 13'h003f;
   localparam logic [12:0] MASK_DIV16      = 13'h000f;
   localparam logic [12:0] MASK_DIV4       = 13'h0003;
   localparam logic [12:0] MASK_NONE       = 13'h0000;

   // Subclock divider value at the last of the four edges per count.
   localparam logic [1:0]  SUB_DIV_LAST    = 2'h3;

   // Count source codes.
   typedef enum logic [2:0] {
      SRC_DIV8192 = 3'h0,
      SRC_DIV2048 = 3'h1,
      SRC_DIV512  = 3'h2,
      SRC_DIV64   = 3'h3,
      SRC_DIV16   = 3'h4,
      SRC_DIV4    = 3'h5,
      SRC_SUB4    = 3'h6,
      SRC_EVENT   = 3'h7
   } udrt_src_t;

endpackage
`default_nettype wire

// [logic/udrt_prescaler.sv]
`timescale 1ns/1ps
`default_nettype none
module udrt_prescaler (
   // Clock and reset.
   input  wire logic       mclk,
   input  wire logic       rst,
   // Source selection and tick.
   input  wire logic [2:0] source_select,
   output logic            internal_tick
);

   logic [udrt_pkg::PRESCALE_WIDTH-1:0] prescale;
   logic [12:0]                         mask;
   logic                                is_prescaled;
   logic                                next_tick;

   // Returns the low prescaler bits that must all be set for one tick.
   function automatic logic [12:0] div_mask(input logic [2:0] sel);
      case (sel)
         udrt_pkg::SRC_DIV8192: div_mask = udrt_pkg::MASK_DIV8192;
         udrt_pkg::SRC_DIV2048: div_mask = udrt_pkg::MASK_DIV2048;
         udrt_pkg::SRC_DIV512:  div_mask = udrt_pkg::MASK_DIV512;
         udrt_pkg::SRC_DIV64:   div_mask = udrt_pkg::MASK_DIV64;
         udrt_pkg::SRC_DIV16:   div_mask = udrt_pkg::MASK_DIV16;
         udrt_pkg::SRC_DIV4:    div_mask = udrt_pkg::MASK_DIV4;
         default:               div_mask = udrt_pkg::MASK_NONE;
      endcase
   endfunction

   assign mask         = div_mask(source_select);
   assign is_prescaled = (source_select < udrt_pkg::SRC_SUB4);
   assign next_tick    = is_prescaled && ((prescale & mask) == mask);

   // Free running divider, one tick per divide period.
   always_ff @(posedge mclk) begin
      if (rst) begin
         prescale      <= '0;
         internal_tick <= 1'b0;
      end else begin
         prescale      <= prescale + 13'h0001;
         internal_tick <= next_tick;
      end
   end

endmodule // udrt_prescaler
`default_nettype wire

// [verification/udrt_pin_model.sv]
`timescale 1ns/1ps
`default_nettype none
module udrt_pin_model (
   // Clock.
   input  wire logic mclk,
   // Pins driven toward the timer.
   output logic      direction_pin,
   output logic      event_input_pin,
   output logic      subclock_pin
);

   initial begin
      direction_pin   = 1'b0;
      event_input_pin = 1'b0;
      subclock_pin    = 1'b0;
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Sets the direction level, held until the next change.
   task automatic set_dir(input logic level);
      @(posedge mclk);
      direction_pin <= level;
   endtask

   // Gives whole pulses, each level held long enough for the synchroniser.
   // The subclock stands still between bursts.
   task automatic pulse(input logic sub, input int n);
      for (int i = 0; i < n; i++) begin
         @(posedge mclk);
         if (sub) subclock_pin <= 1'b1;
         else event_input_pin <= 1'b1;
         repeat (3) @(posedge mclk);
         if (sub) subclock_pin <= 1'b0;
         else event_input_pin <= 1'b0;
         repeat (3) @(posedge mclk);
      end
   endtask

endmodule // udrt_pin_model
`default_nettype wire

// [verification/updown_reload_timer_8bit_bench.sv]
`timescale 1ns/1ps
`default_nettype none
module updown_reload_timer_8bit_bench;

   logic        mclk;
   logic        rst;
   logic [11:0] paddr;
   logic        psel;
   logic        penable;
   logic        pwrite;
   logic [31:0] pwdata;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic        direction_pin;
   logic        event_input_pin;
   logic        subclock_pin;
   logic        low_speed_mode;
   logic        timer_irq;
   int          miscompares;
   int          samples_checked;
   logic [33:0] expect_q[$];
   logic [7:0]  v;
   int          divs[6] = '{8192, 2048, 512, 64, 16, 4};

   udrt_timer uut (
      .mclk            (mclk),
      .rst             (rst),
      .paddr           (paddr),
      .psel            (psel),
      .penable         (penable),
      .pwrite          (pwrite),
      .pwdata          (pwdata),
      .prdata          (prdata),
      .pready          (pready),
      .pslverr         (pslverr),
      .direction_pin   (direction_pin),
      .event_input_pin (event_input_pin),
      .subclock_pin    (subclock_pin),
      .low_speed_mode  (low_speed_mode),
      .timer_irq       (timer_irq)
   );

   udrt_pin_model pins (
      .mclk            (mclk),
      .direction_pin   (direction_pin),
      .event_input_pin (event_input_pin),
      .subclock_pin    (subclock_pin)
   );

   initial begin
      mclk = 1'b0;
      forever #20 mclk = ~mclk;
   end

   ////////////////////////////////////////////////////////////////////////////////
   task automatic report_and_stop;
      if (miscompares == 0 && samples_checked > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   task automatic cmp(input logic [33:0] exp, input logic [33:0] got);
      samples_checked++;
      if (got !== exp) begin
         miscompares++;
         $display("BAD %0t read %h expected %h", $time, got, exp);
      end
   endtask

   // Compares each completed read, with its error and interrupt lines, to the oldest note.
   always @(posedge mclk) begin
      if (psel && penable && pready && !pwrite) begin
         if (expect_q.size() == 0) begin
            miscompares++;
            $display("BAD %0t read with no expectation", $time);
         end else begin
            cmp(expect_q.pop_front(), {pslverr, timer_irq, prdata});
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      int n;
      @(posedge mclk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= d;
      @(posedge mclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge mclk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (n >= 50) begin
         miscompares++;
         $display("BAD %0t no ready", $time);
         report_and_stop();
      end
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wr(input logic [11:0] a, input logic [7:0] d);
      apb(1'b1, a, {24'h000000, d});
   endtask

   task automatic rd(input logic [11:0] a, input logic [7:0] e, input logic irq,
                     input logic err = 1'b0);
      expect_q.push_back({err, irq, 24'h000000, e});
      apb(1'b0, a, 32'h00000000);
   endtask

   task automatic ev(input int n);
      pins.pulse(1'b0, n);
      repeat (6) @(posedge mclk);
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (100000) @(posedge mclk);
      miscompares++;
      $display("BAD %0t run too long", $time);
      report_and_stop();
   end

   initial begin
      rst = 1'b1;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h00000000;
      low_speed_mode = 1'b0;
      miscompares = 0;
      samples_checked = 0;
      v = 8'($urandom(32'h570024f3));
      repeat (5) @(posedge mclk);
      rst <= 1'b0;
      rd(udrt_pkg::ADDR_MODE, 8'h18, 1'b0);
      rd(udrt_pkg::ADDR_COUNT, 8'h00, 1'b0);
      rd(udrt_pkg::ADDR_STANDBY, 8'hff, 1'b0);
      rd(udrt_pkg::ADDR_IRQ, 8'h00, 1'b0);
      rd(12'h010, 8'h00, 1'b0, 1'b1);
      wr(udrt_pkg::ADDR_MODE, 8'he7);
      rd(udrt_pkg::ADDR_MODE, 8'hff, 1'b0);
      wr(udrt_pkg::ADDR_MODE, 8'h00);
      rd(udrt_pkg::ADDR_MODE, 8'h18, 1'b0);
      // Each window spans whole prescaler periods, so the tick count is exact.
      for (int i = 0; i < 6; i++) begin
         wr(udrt_pkg::ADDR_MODE, {5'h03, i[2:0]});
         wr(udrt_pkg::ADDR_COUNT, 8'h00);
         repeat ((i + 2) * divs[i] - 2) @(posedge mclk);
         rd(udrt_pkg::ADDR_COUNT, 8'(i + 2), 1'b0);
      end
      low_speed_mode <= 1'b1;
      wr(udrt_pkg::ADDR_MODE, 8'h05);
      wr(udrt_pkg::ADDR_COUNT, 8'h00);
      repeat (100) @(posedge mclk);
      rd(udrt_pkg::ADDR_COUNT, 8'h00, 1'b0);
      wr(udrt_pkg::ADDR_MODE, 8'h06);
      wr(udrt_pkg::ADDR_COUNT, 8'h10);
      pins.pulse(1'b1, 8);
      repeat (6) @(posedge mclk);
      rd(udrt_pkg::ADDR_COUNT, 8'h12, 1'b0);
      low_speed_mode <= 1'b0;
      wr(udrt_pkg::ADDR_IRQ, 8'h06);
      wr(udrt_pkg::ADDR_MODE, 8'h07);
      v = 8'($urandom_range(0, 252));
      wr(udrt_pkg::ADDR_COUNT, v);
      rd(udrt_pkg::ADDR_COUNT, v, 1'b0);
      ev(2);
      rd(udrt_pkg::ADDR_COUNT, v + 8'h02, 1'b0);
      wr(udrt_pkg::ADDR_COUNT, 8'hfe);
      ev(2);
      rd(udrt_pkg::ADDR_COUNT, 8'h00, 1'b1);
      rd(udrt_pkg::ADDR_IRQ, 8'h07, 1'b1);
      wr(udrt_pkg::ADDR_IRQ, 8'h07);
      rd(udrt_pkg::ADDR_IRQ, 8'h06, 1'b0);
      wr(udrt_pkg::ADDR_MODE, 8'h27);
      wr(udrt_pkg::ADDR_COUNT, 8'h01);
      ev(2);
      rd(udrt_pkg::ADDR_COUNT, 8'hff, 1'b1);
      wr(udrt_pkg::ADDR_IRQ, 8'h07);
      pins.set_dir(1'b1);
      wr(udrt_pkg::ADDR_MODE, 8'h47);
      wr(udrt_pkg::ADDR_COUNT, 8'h80);
      ev(1);
      rd(udrt_pkg::ADDR_COUNT, 8'h7f, 1'b0);
      pins.set_dir(1'b0);
      wr(udrt_pkg::ADDR_MODE, 8'h67);
      ev(1);
      rd(udrt_pkg::ADDR_COUNT, 8'h80, 1'b0);
      wr(udrt_pkg::ADDR_MODE, 8'h87);
      wr(udrt_pkg::ADDR_COUNT, 8'hfd);
      ev(3);
      rd(udrt_pkg::ADDR_COUNT, 8'hfd, 1'b1);
      wr(udrt_pkg::ADDR_IRQ, 8'h07);
      wr(udrt_pkg::ADDR_MODE, 8'ha7);
      wr(udrt_pkg::ADDR_COUNT, 8'h02);
      ev(3);
      rd(udrt_pkg::ADDR_COUNT, 8'h02, 1'b1);
      wr(udrt_pkg::ADDR_IRQ, 8'h07);
      wr(udrt_pkg::ADDR_STANDBY, 8'hfd);
      rd(udrt_pkg::ADDR_STANDBY, 8'hfd, 1'b0);
      ev(2);
      rd(udrt_pkg::ADDR_COUNT, 8'h02, 1'b0);
      wr(udrt_pkg::ADDR_STANDBY, 8'hff);
      ev(1);
      rd(udrt_pkg::ADDR_COUNT, 8'h01, 1'b0);
      wr(udrt_pkg::ADDR_IRQ, 8'h02);
      ev(1);
      rd(udrt_pkg::ADDR_COUNT, 8'h00, 1'b0);
      @(posedge mclk);
      rst <= 1'b1;
      repeat (2) @(posedge mclk);
      rst <= 1'b0;
      rd(udrt_pkg::ADDR_MODE, 8'h18, 1'b0);
      rd(udrt_pkg::ADDR_COUNT, 8'h00, 1'b0);
      repeat (4) @(posedge mclk);
      report_and_stop();
   end

endmodule // updown_reload_timer_8bit_bench
`default_nettype wire
